// ===== rtl/ppcc_pkg.sv
// package: register map, field positions and constants for the path parity checker
package ppcc_pkg;
    localparam int          PPCC_AW             = 13;
    localparam int          PPCC_DW             = 8;
    // register byte addresses
    localparam logic [12:0] PPCC_ADDR_CTRL      = 13'h1183;
    localparam logic [12:0] PPCC_ADDR_ISTAT     = 13'h118b;
    localparam logic [12:0] PPCC_ADDR_IMASK     = 13'h118f;
    localparam logic [12:0] PPCC_ADDR_CNT3      = 13'h1198;
    localparam logic [12:0] PPCC_ADDR_CNT2      = 13'h1199;
    localparam logic [12:0] PPCC_ADDR_CNT1      = 13'h119a;
    localparam logic [12:0] PPCC_ADDR_CNT0      = 13'h119b;
    // control fields
    localparam int          PPCC_CTRL_GRAN_BIT  = 0;
    localparam logic [3:0]  PPCC_CTRL_WMASK     = 4'hf;
    localparam logic [7:0]  PPCC_CTRL_RST       = 8'h00;
    // interrupt status fields, mask reset value, counter and tally widths
    localparam int          PPCC_ISTAT_ERR_BIT  = 7;
    localparam logic [7:0]  PPCC_IMASK_RST      = 8'h00;
    localparam int          PPCC_CNT_W          = 32;
    localparam int          PPCC_TALLY_W        = 4;
endpackage

// ===== rtl/ppcc_bip8.sv
// bip-8 accumulator over the bytes of one payload envelope
`timescale 1ns/1ps
module ppcc_bip8 (
    // clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       sys_rst_i,
    // byte stream
    input  wire logic       start_i,
    input  wire logic       byte_vld_i,
    input  wire logic [7:0] byte_i,
    // result of the envelope just closed
    output logic      [7:0] parity_o
);
    logic [7:0] acc_r;
    logic [7:0] acc_nxt;
    logic [7:0] parity_r;
    logic [7:0] parity_nxt;

    // even parity per bit lane, restarted at each envelope start
    always_comb begin
        acc_nxt    = acc_r;
        parity_nxt = parity_r;
        if (start_i) begin
            parity_nxt = acc_r;
            acc_nxt    = byte_vld_i ? byte_i : 8'h00;
        end else if (byte_vld_i) begin
            acc_nxt = acc_r ^ byte_i;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            acc_r    <= 8'h00;
            parity_r <= 8'h00;
        end else begin
            acc_r    <= acc_nxt;
            parity_r <= parity_nxt;
        end
    end

    assign parity_o = parity_r;

    a_parity_latch: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        start_i |=> parity_o == $past(acc_r))
        else $error("envelope parity not latched at start");
endmodule

// ===== rtl/ppcc_top.sv
// path parity checker: bip-8 check, error counter, interrupt and remote error tally
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module ppcc_top
    import ppcc_pkg::*;
(
    // clock and reset
    input  wire logic                       clk_sys_i,
    input  wire logic                       sys_rst_i,
    // received envelope byte stream
    input  wire logic                       env_start_i,
    input  wire logic                       byte_vld_i,
    input  wire logic [7:0]                 byte_i,
    input  wire logic                       parity_byte_i,
    // register port
    input  wire logic [ppcc_pkg::PPCC_AW-1:0] reg_addr_i,
    input  wire logic [ppcc_pkg::PPCC_DW-1:0] reg_wdata_i,
    input  wire logic                       reg_wr_i,
    input  wire logic                       reg_rd_i,
    output logic      [ppcc_pkg::PPCC_DW-1:0] reg_rdata_o,
    // transmit side
    output logic      [ppcc_pkg::PPCC_TALLY_W-1:0] remote_error_tally_o,
    output logic                            remote_error_vld_o,
    // interrupt
    output logic                            irq_n_o
);
    import ppcc_pkg::*;

    function automatic logic [3:0] popcount8(input logic [7:0] v);
        logic [3:0] c;
        c = 4'h0;
        for (int i = 0; i < 8; i++) begin
            c = c + {3'h0, v[i]};
        end
        return c;
    endfunction

    logic [7:0]  parity_w;
    logic        granularity;
    logic [7:0]  ctrl_r,  ctrl_nxt;
    logic [7:0]  istat_r, istat_nxt;
    logic [7:0]  imask_r, imask_nxt;
    logic [31:0] cnt_r,   cnt_nxt;
    logic [31:0] snap_r,  snap_nxt;
    logic        have_r,  have_nxt;
    logic        seen_r,  seen_nxt;
    logic        rd_istat;
    logic        rd_cnt3;
    logic [7:0]  b3_r,    b3_nxt;
    logic        chk_r,   chk_nxt;
    logic [3:0]  tally_r, tally_nxt;
    logic        tvld_r,  tvld_nxt;
    logic [7:0]  rdata_r, rdata_nxt;
    logic [7:0]  diff;
    logic        err;
    logic [3:0]  inc;

    ppcc_bip8 u_bip8 (
        .clk_sys_i  (clk_sys_i),
        .sys_rst_i  (sys_rst_i),
        .start_i    (env_start_i),
        .byte_vld_i (byte_vld_i),
        .byte_i     (byte_i),
        .parity_o   (parity_w)
    );

    assign granularity = ctrl_r[PPCC_CTRL_GRAN_BIT];

    // envelope tracking: a check needs one whole envelope behind the current one
    always_comb begin
        seen_nxt = seen_r;
        have_nxt = have_r;
        b3_nxt   = b3_r;
        chk_nxt  = 1'b0;
        if (env_start_i) begin
            seen_nxt = 1'b1;
            have_nxt = have_r | seen_r;
        end
        if (byte_vld_i && parity_byte_i) begin
            b3_nxt  = byte_i;
            chk_nxt = have_r;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            seen_r <= 1'b0;
            have_r <= 1'b0;
            b3_r   <= 8'h00;
            chk_r  <= 1'b0;
        end else begin
            seen_r <= seen_nxt;
            have_r <= have_nxt;
            b3_r   <= b3_nxt;
            chk_r  <= chk_nxt;
        end
    end

    // parity_w holds the previous envelope's bip-8 from its start onward
    assign diff = chk_r ? (parity_w ^ b3_r) : 8'h00;
    assign err  = (diff != 8'h00);
    assign inc  = granularity ? {3'h0, err} : popcount8(diff);

    assign rd_istat = reg_rd_i && (reg_addr_i == PPCC_ADDR_ISTAT);
    assign rd_cnt3  = reg_rd_i && (reg_addr_i == PPCC_ADDR_CNT3);

    // check result to the transmit side, errored or not
    always_comb begin
        tally_nxt = tally_r;
        tvld_nxt  = 1'b0;
        if (chk_r) begin
            tally_nxt = inc;
            tvld_nxt  = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tally_r <= 4'h0;
            tvld_r  <= 1'b0;
        end else begin
            tally_r <= tally_nxt;
            tvld_r  <= tvld_nxt;
        end
    end

    // control and mask registers; ctrl bits 7:4 and all imask bits but bit 7 read as zero, ctrl bits 3:1 keep what was written
    always_comb begin
        ctrl_nxt  = ctrl_r;
        imask_nxt = imask_r;
        if (reg_wr_i) begin
            case (reg_addr_i)
                PPCC_ADDR_CTRL: begin
                    ctrl_nxt = {4'h0, reg_wdata_i[3:0] & PPCC_CTRL_WMASK};
                end
                PPCC_ADDR_IMASK: begin
                    imask_nxt                     = 8'h00;
                    imask_nxt[PPCC_ISTAT_ERR_BIT] = reg_wdata_i[PPCC_ISTAT_ERR_BIT];
                end
                default: begin
                    ctrl_nxt = ctrl_r;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_r  <= PPCC_CTRL_RST;
            imask_r <= PPCC_IMASK_RST;
        end else begin
            ctrl_r  <= ctrl_nxt;
            imask_r <= imask_nxt;
        end
    end

    // status: read clears, an error in the same cycle wins
    always_comb begin
        istat_nxt = istat_r;
        if (rd_istat) begin
            istat_nxt = 8'h00;
        end
        if (err) begin
            istat_nxt[PPCC_ISTAT_ERR_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            istat_r <= 8'h00;
        end else begin
            istat_r <= istat_nxt;
        end
    end

    // top byte read snapshots and clears; an error in that cycle lands in the new count
    always_comb begin
        cnt_nxt  = cnt_r;
        snap_nxt = snap_r;
        if (rd_cnt3) begin
            snap_nxt = cnt_r;
            cnt_nxt  = 32'h0000_0000;
        end
        if (err) begin
            cnt_nxt = cnt_nxt + {28'h0, inc};
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_r  <= 32'h0000_0000;
            snap_r <= 32'h0000_0000;
        end else begin
            cnt_r  <= cnt_nxt;
            snap_r <= snap_nxt;
        end
    end

    // read data stands only in the cycle after the strobe
    always_comb begin
        rdata_nxt = 8'h00;
        if (reg_rd_i) begin
            case (reg_addr_i)
                PPCC_ADDR_CTRL:  rdata_nxt = ctrl_r;
                PPCC_ADDR_ISTAT: rdata_nxt = istat_r;
                PPCC_ADDR_IMASK: rdata_nxt = imask_r;
                PPCC_ADDR_CNT3:  rdata_nxt = cnt_r[31:24];
                PPCC_ADDR_CNT2:  rdata_nxt = snap_r[23:16];
                PPCC_ADDR_CNT1:  rdata_nxt = snap_r[15:8];
                PPCC_ADDR_CNT0:  rdata_nxt = snap_r[7:0];
                default:         rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata_o          = rdata_r;
    assign remote_error_tally_o = tally_r;
    assign remote_error_vld_o   = tvld_r;
    assign irq_n_o              = ~|(istat_r & imask_r);

    // parity byte of an envelope that has a predecessor
    sequence s_parity_taken;
        byte_vld_i && parity_byte_i && have_r;
    endsequence

    // internal check, then the result on the transmit side
    sequence s_check_done;
        chk_r ##1 remote_error_vld_o;
    endsequence

    a_check_step: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        s_parity_taken |=> s_check_done)
        else $error("parity byte not followed by a check");
    a_compare_next: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (byte_vld_i && parity_byte_i && !have_r) |=> !chk_r)
        else $error("first envelope compared");

    a_status_sets: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        err |=> istat_r[PPCC_ISTAT_ERR_BIT])
        else $error("status bit not set after parity error");
    a_irq_on_error: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (err && imask_r[PPCC_ISTAT_ERR_BIT] && !(reg_wr_i && reg_addr_i == PPCC_ADDR_IMASK)) |=> !irq_n_o)
        else $error("irq not raised on enabled parity error");
    a_irq_level: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (rd_istat && !err) |=> irq_n_o)
        else $error("irq not released after status read");

    a_envelope_count: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (err && granularity && !rd_cnt3) |=> cnt_r == $past(cnt_r) + 32'h1)
        else $error("per-envelope count not one");
    a_bit_count: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (chk_r && !granularity && !rd_cnt3)
        |=> cnt_r == $past(cnt_r) + {28'h0, popcount8($past(diff))})
        else $error("per-bit count wrong");
    a_clear_counts: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        rd_cnt3 |=> cnt_r == {28'h0, $past(inc & {4{err}})})
        else $error("counter not restarted on top byte read");

    a_tally_one: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (remote_error_vld_o && granularity) |-> remote_error_tally_o <= 4'h1)
        else $error("tally above one in envelope mode");
    a_tally_eight: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        remote_error_tally_o <= 4'h8)
        else $error("tally above eight");
    a_tally_follows: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        chk_r |=> remote_error_vld_o && remote_error_tally_o == $past(inc))
        else $error("tally not forwarded");

    a_snap_coherent: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        rd_cnt3 |=> snap_r == $past(cnt_r))
        else $error("snapshot not coherent");
    a_counter_width: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        rd_cnt3 |=> reg_rdata_o == $past(cnt_r[31:24]))
        else $error("top counter byte wrong");
    a_rdata_idle: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        !reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data present without a read");
endmodule

// ===== sim/ppcc_far_pte.sv
// far-end path terminating equipment model: envelopes ending in a parity byte
`timescale 1ns/1ps
module ppcc_far_pte #(
    parameter int ENV_LEN = 6
) (
    // clock
    input  wire logic       clk_sys_i,
    // envelope byte stream
    output logic            env_start_o,
    output logic            byte_vld_o,
    output logic      [7:0] byte_o,
    output logic            parity_byte_o
);
    logic [7:0] bip_prev = 8'h00;

    initial begin
        env_start_o   = 1'b0;
        byte_vld_o    = 1'b0;
        byte_o        = 8'h00;
        parity_byte_o = 1'b0;
    end

    // last byte carries parity of previous envelope, bits flipped by err_mask
    task automatic send_env(input logic [7:0] err_mask);
        logic [7:0] acc;
        logic [7:0] b;
        acc = 8'h00;
        b   = 8'h00;
        for (int i = 0; i < ENV_LEN; i++) begin
            @(posedge clk_sys_i);
            b = (i == ENV_LEN - 1) ? (bip_prev ^ err_mask) : (bip_prev + 8'(i * 29));
            acc = acc ^ b;
            env_start_o   <= (i == 0);
            byte_vld_o    <= 1'b1;
            byte_o        <= b;
            parity_byte_o <= (i == ENV_LEN - 1);
        end
        @(posedge clk_sys_i);
        env_start_o   <= 1'b0;
        byte_vld_o    <= 1'b0;
        parity_byte_o <= 1'b0;
        // idle line shows no stale byte
        byte_o        <= ~b;
        bip_prev = acc;
    endtask
endmodule

// ===== sim/ppcc_top_tb.sv
// testbench for the path parity checker: register access, counting modes, interrupt
`timescale 1ns/1ps
module ppcc_top_tb;
    import ppcc_pkg::*;
    logic        clk, rst, env_start, byte_vld, par_byte, wr, rd, tally_vld, irq_n;
    logic [7:0]  byte_d, wdata, rdata, v;
    logic [12:0] addr;
    logic [3:0]  tally, e;
    logic [31:0] cnt, sum;
    int          mismatches, total_checks, cycles;
    logic [7:0]  masks [4] = '{8'h00, 8'h01, 8'h81, 8'hff};
    logic [12:0] rst_addrs [5] = '{PPCC_ADDR_CTRL, PPCC_ADDR_ISTAT, PPCC_ADDR_IMASK, PPCC_ADDR_CNT3, 13'h1000};

    ppcc_far_pte u_far (.clk_sys_i(clk), .env_start_o(env_start), .byte_vld_o(byte_vld), .byte_o(byte_d),
                        .parity_byte_o(par_byte));
    ppcc_top u_dut (.clk_sys_i(clk), .sys_rst_i(rst), .env_start_i(env_start), .byte_vld_i(byte_vld),
                    .byte_i(byte_d), .parity_byte_i(par_byte), .reg_addr_i(addr), .reg_wdata_i(wdata),
                    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .remote_error_tally_o(tally),
                    .remote_error_vld_o(tally_vld), .irq_n_o(irq_n));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            final_report;
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [12:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [12:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask

    // one envelope, then the check result must reach the transmit side
    task automatic env_chk(input logic [7:0] m, input logic [3:0] exp);
        logic seen;
        seen = 1'b0;
        u_far.send_env(m);
        for (int i = 0; i < 8 && !seen; i++) begin
            @(posedge clk);
            #1 seen = (tally_vld === 1'b1);
        end
        chk("tally_vld", 32'(seen), 32'h1);
        chk("tally", 32'(tally), 32'(exp));
    endtask

    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 13'h0000;
        wdata = 8'h00;
        mismatches = 0;
        total_checks = 0;
        cycles = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        foreach (rst_addrs[i]) begin
            rd_reg(rst_addrs[i], v);
            chk("reset_value", 32'(v), 32'h0);
        end
        chk("irq_n_idle", 32'(irq_n), 32'h1);
        wr_reg(PPCC_ADDR_CTRL, 8'hff);
        wr_reg(13'h1001, 8'h5a);
        rd_reg(PPCC_ADDR_CTRL, v);
        chk("ctrl_rw", 32'(v), 32'h0f);
        // first envelope only seeds the previous parity: a bad parity byte must go unchecked
        u_far.send_env(8'h5a);
        v = 8'h00;
        repeat (4) begin
            @(posedge clk);
            #1 v = v | 8'(tally_vld);
        end
        chk("first_unchecked", 32'(v), 32'h0);
        for (int g = 0; g < 2; g++) begin
            wr_reg(PPCC_ADDR_CTRL, 8'(g));
            wr_reg(PPCC_ADDR_IMASK, g ? 8'h80 : 8'h00);
            sum = 32'h0;
            foreach (masks[i]) begin
                e = g ? 4'(masks[i] != 8'h00) : 4'($countones(masks[i]));
                env_chk(masks[i], e);
                sum = sum + 32'(e);
            end
            // snapshot on top byte read, then count on while reading the rest
            rd_reg(PPCC_ADDR_CNT3, cnt[31:24]);
            env_chk(8'h03, g ? 4'h1 : 4'h2);
            rd_reg(PPCC_ADDR_CNT2, cnt[23:16]);
            rd_reg(PPCC_ADDR_CNT1, cnt[15:8]);
            rd_reg(PPCC_ADDR_CNT0, cnt[7:0]);
            chk("count_snapshot", cnt, sum);
            chk("irq_n_pending", 32'(irq_n), g ? 32'h0 : 32'h1);
            rd_reg(PPCC_ADDR_ISTAT, v);
            chk("status", 32'(v), 32'h80);
            @(posedge clk);
            #1 chk("irq_n_released", 32'(irq_n), 32'h1);
            rd_reg(PPCC_ADDR_ISTAT, v);
            chk("status_cleared", 32'(v), 32'h0);
            rd_reg(PPCC_ADDR_CNT3, cnt[31:24]);
            rd_reg(PPCC_ADDR_CNT2, cnt[23:16]);
            rd_reg(PPCC_ADDR_CNT1, cnt[15:8]);
            rd_reg(PPCC_ADDR_CNT0, cnt[7:0]);
            chk("count_after_clear", cnt, g ? 32'h1 : 32'h2);
        end
        final_report;
    end
endmodule
